// ---- shared/paq_regs.vh ----
// register indices, field positions and reset values of the power, aux and queue slice
`ifndef PAQ_REGS_VH
`define PAQ_REGS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define PAQ_IDX_CONFIG 10'h01a
`define PAQ_IDX_CAPTURE_EN 10'h023
`define PAQ_IDX_EVENT_STATUS 10'h03a
`define PAQ_IDX_USER_CTRL 10'h06a
`define PAQ_IDX_AXIS_STANDBY 10'h06c
`define PAQ_IDX_AUX_SELECT 10'h070
`define PAQ_IDX_COUNT_HIGH 10'h072
`define PAQ_IDX_COUNT_LOW 10'h073
`define PAQ_IDX_DATA_PORT 10'h074

// ==========================================================
// field positions
`define PAQ_BIT_SLEEP_INHIBIT 7
`define PAQ_BIT_ACCEL_X_STBY 5
`define PAQ_BIT_ACCEL_Z_STBY 3
`define PAQ_BIT_GYRO_X_STBY 2
`define PAQ_BIT_GYRO_Z_STBY 0
`define PAQ_BIT_AUX_SELECT 1
`define PAQ_BIT_FULL_POLICY 6
`define PAQ_BIT_QUEUE_EN 6
`define PAQ_BIT_QUEUE_RST 2
`define PAQ_BIT_OVERRUN 4
`define PAQ_CAPTURE_W 7

// ==========================================================
// reset values and fixed codes
`define PAQ_RST_AXIS_STANDBY 8'h00
`define PAQ_RST_AUX_SELECT 1'b0
`define PAQ_RST_CONFIG 1'b0
`define PAQ_RST_CAPTURE_EN 7'h00
`define PAQ_RST_USER_CTRL 1'b0
`define PAQ_EMPTY_MARK 8'hff
`define PAQ_SUBST_MARK 8'hfe
`define PAQ_SENSOR_BYTES 14
`define PAQ_QUEUE_DEPTH 512

`endif

// ---- design/paq_regs_top.v ----
// power, aux-port and byte-queue register slice with apb slave
//
// Contract
// - sleep inhibit keeps device awake in accel-off
// - inhibit clear lets device sleep when idle
// - accel standby bits disable each accel axis
// - aux select one makes aux spi slave
// - aux select zero makes aux i2c master
// - byte count split into high, low registers
// - high count read latches both count bytes
// - low count read arms fresh count latch
// - data port read pops, write pushes byte
// - sample bytes pushed lowest register first
// - only capture-enabled sensor bytes are queued
// - overflow sets overrun flag in status
// - overflow drops oldest unless full policy set
// - empty queue read returns ff repeatedly
// - genuine queue data never equals ff
// - queue enable bit gates queue operation
// - queue reset bit resets, self-clears next cycle
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "paq_regs.vh"

module paq_regs_top #(
    parameter DEPTH = `PAQ_QUEUE_DEPTH,
    parameter AW = 9
) (
    input wire SYS_CLK_I,
    input wire SYS_RST_I,
    input wire CE_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    input wire SAMPLE_TICK_I,
    input wire [111:0] SENSOR_DATA_I,
    input wire DUTY_CYCLE_I,
    input wire ACCEL_OFF_I,
    output reg [2:0] ACCEL_STBY_O,
    output reg [2:0] GYRO_STBY_O,
    output reg SLEEP_O,
    output reg AUX_SPI_SLAVE_O,
    output reg AUX_I2C_MASTER_O,
    output reg OVERRUN_O
);

    // ==========================================================
    // software registers
    reg [7:0] axis_standby_power_ctrl;
    reg aux_port_select;
    reg full_policy;
    reg [`PAQ_CAPTURE_W-1:0] capture_en;
    reg queue_en;
    reg queue_rst;
    reg queue_overrun_flag;
    reg [15:0] count_snap;
    reg count_armed;
    reg rd_pop_ok;

    // ==========================================================
    // queue state
    reg [7:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [15:0] count;
    reg seq_busy;
    reg [3:0] seq_idx;
    reg [111:0] seq_bytes;
    reg [`PAQ_CAPTURE_W-1:0] seq_mask;

    // ==========================================================
    // bus decode
    wire [9:0] idx = PADDR_I[11:2];
    wire setup = CE_I & PSEL_I & ~PENABLE_I;
    wire access = CE_I & PSEL_I & PENABLE_I & PREADY_O;
    wire acc_wr = access & PWRITE_I;
    wire acc_rd = access & ~PWRITE_I;
    // a refused read must not pop, latch or clear anything
    wire rd_ok = acc_rd & (PADDR_I[1:0] == 2'b00);
    wire is_data = (idx == `PAQ_IDX_DATA_PORT);
    // count is 16 bits wide whatever the depth; the parameter is cut on purpose
    wire [31:0] depth_full = DEPTH;
    wire [15:0] depth16 = depth_full[15:0];
    wire empty = (count == 16'h0000);
    wire full = (count == depth16);

    reg mapped;
    reg [7:0] rd_byte;
    always @* begin
        mapped = (PADDR_I[1:0] == 2'b00);
        rd_byte = 8'h00;
        case (idx)
            `PAQ_IDX_CONFIG: rd_byte = {1'b0, full_policy, 6'h00};
            `PAQ_IDX_CAPTURE_EN: rd_byte = {1'b0, capture_en};
            `PAQ_IDX_EVENT_STATUS: rd_byte = {3'h0, queue_overrun_flag, 4'h0};
            `PAQ_IDX_USER_CTRL: rd_byte = {1'b0, queue_en, 3'h0, queue_rst, 2'h0};
            `PAQ_IDX_AXIS_STANDBY: rd_byte = {axis_standby_power_ctrl[7], 1'b0,
                axis_standby_power_ctrl[5:0]};
            `PAQ_IDX_AUX_SELECT: rd_byte = {6'h00, aux_port_select, 1'b0};
            // a fresh value is shown only while armed; afterwards the snapshot
            `PAQ_IDX_COUNT_HIGH: rd_byte = count_armed ? count[15:8] : count_snap[15:8];
            `PAQ_IDX_COUNT_LOW: rd_byte = count_armed ? count[7:0] : count_snap[7:0];
            `PAQ_IDX_DATA_PORT: rd_byte = (empty | ~queue_en) ? `PAQ_EMPTY_MARK :
                mem[rd_ptr];
            default: mapped = 1'b0;
        endcase
    end

    // ==========================================================
    // apb answer: data fixed in setup so it is stable through access
    // with clock enable low the slave stays silent and the master just waits
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= 32'h0000_0000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            rd_pop_ok <= 1'b0;
        end else if (CE_I) begin
            PREADY_O <= setup;
            if (setup) begin
                // refused reads return zero so stale bytes never leak out
                PRDATA_O <= (PWRITE_I | ~mapped) ? 32'h0000_0000 : {24'h000000, rd_byte};
                PSLVERR_O <= ~mapped;
                // only a byte actually returned may be popped later
                rd_pop_ok <= is_data & mapped & ~empty & queue_en;
            end
        end
    end

    // ==========================================================
    // control registers
    // reserved standby bit 6 is masked on write so it always reads 0
    wire wr_ok = acc_wr & (PADDR_I[1:0] == 2'b00);
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            axis_standby_power_ctrl <= `PAQ_RST_AXIS_STANDBY;
            aux_port_select <= `PAQ_RST_AUX_SELECT;
            full_policy <= `PAQ_RST_CONFIG;
            capture_en <= `PAQ_RST_CAPTURE_EN;
            queue_en <= `PAQ_RST_USER_CTRL;
            queue_rst <= 1'b0;
        end else if (CE_I) begin
            queue_rst <= 1'b0;
            if (wr_ok) begin
                case (idx)
                    `PAQ_IDX_CONFIG: full_policy <= PWDATA_I[`PAQ_BIT_FULL_POLICY];
                    `PAQ_IDX_CAPTURE_EN: capture_en <= PWDATA_I[`PAQ_CAPTURE_W-1:0];
                    `PAQ_IDX_USER_CTRL: begin
                        queue_en <= PWDATA_I[`PAQ_BIT_QUEUE_EN];
                        queue_rst <= PWDATA_I[`PAQ_BIT_QUEUE_RST];
                    end
                    `PAQ_IDX_AXIS_STANDBY: axis_standby_power_ctrl <= PWDATA_I[7:0] & 8'hbf;
                    `PAQ_IDX_AUX_SELECT: aux_port_select <= PWDATA_I[`PAQ_BIT_AUX_SELECT];
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // count latch pair
    // the snapshot outlives later pushes and pops until the low byte is read
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            count_snap <= 16'h0000;
            count_armed <= 1'b1;
        end else if (CE_I && rd_ok) begin
            if (idx == `PAQ_IDX_COUNT_HIGH && count_armed) begin
                count_snap <= count;
                count_armed <= 1'b0;
            end else if (idx == `PAQ_IDX_COUNT_LOW) begin
                count_armed <= 1'b1;
            end
        end
    end

    // ==========================================================
    // push and pop selection
    wire host_push = wr_ok & is_data & queue_en;
    wire [7:0] seq_byte = seq_bytes[8*seq_idx +: 8];
    wire seq_push = seq_busy & queue_en & ~host_push & seq_mask[seq_idx[3:1]];
    wire push = host_push | seq_push;
    wire [7:0] raw_byte = host_push ? PWDATA_I[7:0] : seq_byte;
    // the empty mark is reserved, so ff data is stored one code lower
    wire [7:0] push_byte = (raw_byte == `PAQ_EMPTY_MARK) ? `PAQ_SUBST_MARK : raw_byte;
    wire pop = rd_ok & is_data & rd_pop_ok & ~empty & queue_en;
    wire over = push & full & ~pop;
    wire do_write = push & ~(over & full_policy);
    wire drop_old = over & ~full_policy;
    wire clr_ovf = rd_ok & (idx == `PAQ_IDX_EVENT_STATUS);

    // ==========================================================
    // pointer wrap; the depth need not be a power of two
    wire [31:0] last_full = DEPTH - 1;
    wire [AW-1:0] last = last_full[AW-1:0];
    wire [AW-1:0] wr_next = (wr_ptr == last) ? {AW{1'b0}} : wr_ptr + 1'b1;
    wire [AW-1:0] rd_next = (rd_ptr == last) ? {AW{1'b0}} : rd_ptr + 1'b1;

    // storage has no reset; the pointers alone say what is valid
    always @(posedge SYS_CLK_I) begin
        if (CE_I && do_write) begin
            mem[wr_ptr] <= push_byte;
        end
    end

    // ==========================================================
    // queue pointers, count and sample sequencer, also cleared by queue reset
    // the clear comes from a flop and lasts one full cycle, so it cannot glitch
    always @(posedge SYS_CLK_I or posedge SYS_RST_I or posedge queue_rst) begin
        if (SYS_RST_I || queue_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= 16'h0000;
            seq_busy <= 1'b0;
            seq_idx <= 4'h0;
            seq_bytes <= 112'h0;
            seq_mask <= {`PAQ_CAPTURE_W{1'b0}};
        end else if (CE_I) begin
            if (do_write) begin
                wr_ptr <= wr_next;
            end
            if (pop || drop_old) begin
                rd_ptr <= rd_next;
            end
            if (do_write && !pop && !drop_old) begin
                count <= count + 16'h0001;
            end else if (pop && !do_write) begin
                count <= count - 16'h0001;
            end
            if (!queue_en) begin
                // disabling the queue abandons a burst in flight
                seq_busy <= 1'b0;
            end else if (!seq_busy) begin
                // a tick during a running burst is ignored
                if (SAMPLE_TICK_I && queue_en && (|capture_en)) begin
                    seq_busy <= 1'b1;
                    seq_idx <= 4'h0;
                    seq_bytes <= SENSOR_DATA_I;
                    seq_mask <= capture_en;
                end
            end else if (!host_push) begin
                // host writes take the slot; the burst just waits a cycle
                seq_idx <= seq_idx + 4'h1;
                if (seq_idx == `PAQ_SENSOR_BYTES - 1) begin
                    seq_busy <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // overrun status, sticky until read; a new overrun beats the clear
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            queue_overrun_flag <= 1'b0;
        end else if (CE_I) begin
            if (over) begin
                queue_overrun_flag <= 1'b1;
            end else if (clr_ovf) begin
                queue_overrun_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // power and aux outputs
    // the gyro counts as disabled only with all three axes in standby
    wire gyro_off = &axis_standby_power_ctrl[`PAQ_BIT_GYRO_X_STBY:`PAQ_BIT_GYRO_Z_STBY];
    wire inhibit = axis_standby_power_ctrl[`PAQ_BIT_SLEEP_INHIBIT];
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ACCEL_STBY_O <= 3'h0;
            GYRO_STBY_O <= 3'h0;
            SLEEP_O <= 1'b0;
            AUX_SPI_SLAVE_O <= 1'b0;
            AUX_I2C_MASTER_O <= 1'b1;
            OVERRUN_O <= 1'b0;
        end else if (CE_I) begin
            ACCEL_STBY_O <= axis_standby_power_ctrl[`PAQ_BIT_ACCEL_X_STBY:
                `PAQ_BIT_ACCEL_Z_STBY];
            GYRO_STBY_O <= axis_standby_power_ctrl[`PAQ_BIT_GYRO_X_STBY:
                `PAQ_BIT_GYRO_Z_STBY];
            // sleep only in accel-off gaps with gyro down and inhibit clear
            SLEEP_O <= DUTY_CYCLE_I & ACCEL_OFF_I & gyro_off & ~inhibit;
            AUX_SPI_SLAVE_O <= aux_port_select;
            AUX_I2C_MASTER_O <= ~aux_port_select;
            OVERRUN_O <= queue_overrun_flag;
        end
    end

endmodule

`default_nettype wire

// ---- bench/paq_regs_chk.sv ----
// port assertions for the power, aux and queue register slice
`timescale 1ns/100ps
`default_nettype none
`include "paq_regs.vh"
module paq_regs_chk (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic DUTY_CYCLE_I,
    input wire logic ACCEL_OFF_I,
    input wire logic [2:0] ACCEL_STBY_O,
    input wire logic [2:0] GYRO_STBY_O,
    input wire logic SLEEP_O,
    input wire logic AUX_SPI_SLAVE_O,
    input wire logic AUX_I2C_MASTER_O,
    input wire logic OVERRUN_O
);
    // ==========================================================
    // helpers
    wire logic [11:0] a_sb = {`PAQ_IDX_AXIS_STANDBY, 2'b00};
    wire logic wr_sb = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && PADDR_I == a_sb;
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    // ==========================================================
    // assertions
    sleep_cause_a: assert property (SLEEP_O && $past(CE_I)
        |-> $past(DUTY_CYCLE_I && ACCEL_OFF_I)) else $error("sleep without accel off interval");
    // standby outputs may move only after a standby write, allowing one extra flop stage
    stby_write_a: assert property ((!$stable(ACCEL_STBY_O) || !$stable(GYRO_STBY_O))
        |-> $past(wr_sb) || $past(wr_sb, 2)) else $error("standby changed without write");
    aux_excl_a: assert property (AUX_I2C_MASTER_O == !AUX_SPI_SLAVE_O)
        else $error("aux port modes not exclusive");
    ready_next_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
        else $error("ready not a pulse after setup");
    ready_cause_a: assert property (PREADY_O |-> $past(PSEL_I && !PENABLE_I))
        else $error("ready without setup");
    bad_align_a: assert property (PREADY_O && $past(PADDR_I[1:0]) != 2'b00 |-> PSLVERR_O)
        else $error("misaligned access not refused");
    good_addr_a: assert property (PREADY_O && $past(PADDR_I) == a_sb |-> !PSLVERR_O)
        else $error("mapped access refused");
    rd_upper_a: assert property (PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
        else $error("read data upper bits set");
    wr_zero_a: assert property (PREADY_O && PWRITE_I |-> PRDATA_O == 32'h0)
        else $error("write returned data");
    cover property (SLEEP_O);
    cover property ($rose(OVERRUN_O));
    cover property (AUX_SPI_SLAVE_O);
endmodule
bind paq_regs_top paq_regs_chk i_paq_regs_chk (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .DUTY_CYCLE_I(DUTY_CYCLE_I), .ACCEL_OFF_I(ACCEL_OFF_I),
    .ACCEL_STBY_O(ACCEL_STBY_O), .GYRO_STBY_O(GYRO_STBY_O), .SLEEP_O(SLEEP_O),
    .AUX_SPI_SLAVE_O(AUX_SPI_SLAVE_O), .AUX_I2C_MASTER_O(AUX_I2C_MASTER_O), .OVERRUN_O(OVERRUN_O));
`default_nettype wire

// ---- bench/paq_sensor_src.sv ----
// sensor sample source feeding the capture side of the register slice
`timescale 1ns/100ps
`default_nettype none
module paq_sensor_src (
    input wire logic go_i,
    output logic tick_o,
    output logic [111:0] data_o
);
    integer k;
    // ==========================================================
    // sample pattern
    // bytes are valid only in the tick cycle; the inverse otherwise exposes a late capture
    always @* begin
        tick_o = go_i;
        for (k = 0; k < 14; k = k + 1) begin
            data_o[8*k +: 8] = go_i ? 8'h10 + k[7:0] : ~(8'h10 + k[7:0]);
        end
    end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the power, aux and queue register slice
`timescale 1ns/100ps
`default_nettype none
`include "paq_regs.vh"
module testbench;
    localparam [11:0] A_SB = {`PAQ_IDX_AXIS_STANDBY, 2'b00}, A_AX = {`PAQ_IDX_AUX_SELECT, 2'b00},
        A_HI = {`PAQ_IDX_COUNT_HIGH, 2'b00}, A_LO = {`PAQ_IDX_COUNT_LOW, 2'b00},
        A_DP = {`PAQ_IDX_DATA_PORT, 2'b00}, A_CF = {`PAQ_IDX_CONFIG, 2'b00},
        A_CE = {`PAQ_IDX_CAPTURE_EN, 2'b00}, A_ST = {`PAQ_IDX_EVENT_STATUS, 2'b00},
        A_UC = {`PAQ_IDX_USER_CTRL, 2'b00};
    logic clk, rst, psel, pen, pwr, go, duty, aoff, er, pready, pslverr, tick, spi, i2c, sleep, ovr;
    logic ce;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, prdata;
    logic [2:0] astb, gstb;
    logic [111:0] sdata;
    integer n_errors, n_checks, i;
    // ==========================================================
    // design and partner
    paq_regs_top #(.DEPTH(8), .AW(3)) i_paq_regs_top (
        .SYS_CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SAMPLE_TICK_I(tick), .SENSOR_DATA_I(sdata),
        .DUTY_CYCLE_I(duty), .ACCEL_OFF_I(aoff), .ACCEL_STBY_O(astb), .GYRO_STBY_O(gstb),
        .SLEEP_O(sleep), .AUX_SPI_SLAVE_O(spi), .AUX_I2C_MASTER_O(i2c), .OVERRUN_O(ovr));
    paq_sensor_src i_paq_sensor_src (.go_i(go), .tick_o(tick), .data_o(sdata));
    // ==========================================================
    // shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwr <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            pen <= 1'b1;
            do @(posedge clk); while (pready !== 1'b1);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd, exp);
        end
    endtask
    task w3;
        repeat (3) @(negedge clk);
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    // ==========================================================
    // scenarios
    task t_regs;
        begin
            rchk(A_SB, 32'h0);
            chk(i2c, 1'b1);
            apb(1'b1, A_SB, 32'hff);
            rchk(A_SB, 32'hbf);
            chk(er, 1'b0);
            apb(1'b1, A_SB, 32'h28);
            w3;
            chk({astb, gstb}, 6'h28);
            apb(1'b1, A_AX, 32'h2);
            w3;
            chk({spi, i2c}, 2'b10);
            apb(1'b1, A_AX, 32'h0);
            w3;
            chk({spi, i2c}, 2'b01);
            apb(1'b0, 12'h1fc, 32'h0);
            chk(er, 1'b1);
            apb(1'b0, A_SB + 12'h1, 32'h0);
            chk(er, 1'b1);
        end
    endtask
    task t_sleep;
        begin
            apb(1'b1, A_SB, 32'h07);
            duty <= 1'b1;
            aoff <= 1'b1;
            w3;
            chk(sleep, 1'b1);
            @(posedge clk);
            ce <= 1'b0;
            aoff <= 1'b0;
            w3;
            chk(sleep, 1'b1);
            @(posedge clk);
            ce <= 1'b1;
            w3;
            chk(sleep, 1'b0);
            @(posedge clk);
            aoff <= 1'b1;
            apb(1'b1, A_SB, 32'h03);
            w3;
            chk(sleep, 1'b0);
            apb(1'b1, A_SB, 32'h87);
            w3;
            chk(sleep, 1'b0);
        end
    endtask
    task t_queue;
        begin
            apb(1'b1, A_DP, 32'h5);
            rchk(A_DP, 32'hff);
            apb(1'b1, A_UC, 32'h40);
            rchk(A_LO, 32'h0);
            rchk(A_DP, 32'hff);
            rchk(A_DP, 32'hff);
            apb(1'b1, A_DP, 32'h33);
            apb(1'b1, A_DP, 32'hff);
            rchk(A_LO, 32'h2);
            rchk(A_DP, 32'h33);
            rchk(A_DP, 32'hfe);
            rchk(A_DP, 32'hff);
        end
    endtask
    task t_stream;
        begin
            apb(1'b1, A_CE, 32'h0);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            rchk(A_LO, 32'h0);
            apb(1'b1, A_CE, 32'h41);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            repeat (20) @(posedge clk);
            rchk(A_LO, 32'h4);
            for (i = 0; i < 4; i = i + 1) rchk(A_DP, (i < 2) ? 32'h10 + i : 32'h1a + i);
        end
    endtask
    task t_over;
        begin
            for (i = 1; i <= 9; i = i + 1) apb(1'b1, A_DP, i);
            rchk(A_LO, 32'h8);
            w3;
            chk(ovr, 1'b1);
            apb(1'b0, A_ST, 32'h0);
            chk(rd, 32'h10);
            for (i = 2; i <= 9; i = i + 1) rchk(A_DP, i);
            chk(ovr, 1'b0);
            apb(1'b1, A_CF, 32'h40);
            for (i = 1; i <= 9; i = i + 1) apb(1'b1, A_DP, i);
            rchk(A_HI, 32'h0);
            chk(ovr, 1'b1);
            rchk(A_DP, 32'h1);
            rchk(A_LO, 32'h8);
            rchk(A_LO, 32'h7);
            apb(1'b1, A_UC, 32'h44);
            rchk(A_UC, 32'h40);
            rchk(A_LO, 32'h0);
            rchk(A_DP, 32'hff);
        end
    endtask
    // ==========================================================
    // run control
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // whole run is near 270 cycles; 4000 leaves ample margin
    initial begin
        #200000;
        n_errors = n_errors + 1;
        stop_test;
    end
    initial begin
        n_errors = 0;
        n_checks = 0;
        {rst, ce, psel, pen, pwr, paddr, pwdata, go, duty, aoff} = {2'b11, 50'h0};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_sleep;
        t_queue;
        t_stream;
        t_over;
        stop_test;
    end
endmodule
`default_nettype wire
